//--- dv/sbsc_core_model.sv
// behavioural memory core that answers the port's read strobe
`default_nettype none
module sbsc_core_model #(
  parameter int W = 18,
  parameter int AW = 19
) (
  // core side of the port
  input wire logic [AW-1:0] mem_addr,
  input wire logic mem_read,
  output logic [W-1:0] core_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // read data
  // data is a fold of the address; outside a read the core gives no
  // valid data, so show the inverse rather than a stale match
  assign core_rdata = mem_read ? W'(mem_addr * 3 + 5) :
                      ~W'(mem_addr * 3 + 5);
endmodule
`default_nettype wire

//--- dv/tb_sbsc_port.sv
// self-checking bench of the burst sram control port
`default_nettype none
module tb_sbsc_port import sbsc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [18:0] addr, mem_addr;
  logic proc_n, ctrl_n, step_n, order, cs_n, sec, gw_n, gate_n;
  logic [1:0] sel_n, mem_lane_write;
  logic [17:0] host_d, data_in, data_out, core_rdata, mem_wdata;
  logic data_oe, mem_read, port_selected;
  int num_errors = 0;
  int cmp_count = 0;
  // 40 MHz clock
  always #12.5 clock = ~clock;
  // pin wire: port drives while enabled, host otherwise
  assign data_in = data_oe ? data_out : host_d;
  // ==========================================================
  // design and core
  sbsc_port sbsc_port_i (.clock(clock), .reset_n(reset_n), .addr(addr),
    .proc_addr_strobe_n(proc_n), .ctrl_addr_strobe_n(ctrl_n),
    .burst_step_n(step_n), .burst_order_high(order),
    .chip_select_n(cs_n), .secondary_select_high(sec),
    .full_word_write_n(gw_n), .byte_write_gate_n(gate_n),
    .lane_write_sel_n(sel_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .core_rdata(core_rdata), .mem_addr(mem_addr),
    .mem_lane_write(mem_lane_write), .mem_wdata(mem_wdata),
    .mem_read(mem_read), .port_selected(port_selected));
  sbsc_core_model sbsc_core_model_i (.mem_addr(mem_addr),
    .mem_read(mem_read), .core_rdata(core_rdata));
  // ==========================================================
  // shared tasks
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // a load with the secondary select low leaves the port idle
  task automatic deselect;
    ctrl_n = 1'b0;
    cs_n = 1'b0;
    sec = 1'b0;
    @(negedge clock);
    ctrl_n = 1'b1;
    check("desel", port_selected, 0);
  endtask
  // ==========================================================
  // scenarios
  // processor strobe while the primary select is high
  task automatic t_gate;
    cs_n = 1'b1;
    sec = 1'b1;
    proc_n = 1'b0;
    addr = 19'h00321;
    @(negedge clock);
    check("gate_sel", port_selected, 0);
    check("gate_rd", mem_read, 0);
    cs_n = 1'b0; // now a real processor load
    @(negedge clock);
    cs_n = 1'b1; // held strobe must neither reload nor deselect
    addr = 19'h00654;
    @(negedge clock);
    proc_n = 1'b1;
    check("gate_hold", port_selected, 1);
    check("gate_wait", mem_addr, 32'h00321);
    check("gate_wrd", mem_read, 1);
    deselect;
  endtask
  // a gated lane select in a burst cycle must stop the read drive
  task automatic t_float;
    @(negedge clock); // let any earlier read drive end
    cs_n = 1'b0;
    sec = 1'b1;
    ctrl_n = 1'b0;
    addr = 19'h00200;
    @(negedge clock);
    ctrl_n = 1'b1;
    gate_n = 1'b0;
    sel_n = 2'b10;
    host_d = 18'h15a5a;
    @(negedge clock);
    gate_n = 1'b1;
    sel_n = 2'b11;
    check("f_oe", data_oe, 0);
    check("f_lanes", mem_lane_write, 32'h1);
    check("f_data", mem_wdata, 32'h15a5a);
    check("f_addr", mem_addr, 32'h00200);
    deselect;
  endtask
  // burst from low bits 01 with one wait cycle in the middle
  task automatic t_burst(input logic ord);
    logic [18:0] a, ea;
    int k;
    a = 19'h12a41;
    k = 0;
    order = ord;
    addr = a;
    cs_n = 1'b0;
    sec = 1'b1;
    proc_n = 1'b0;
    @(negedge clock);
    proc_n = 1'b1;
    addr = ~a; // outside a load the pins must not matter
    for (int n = 0; n < 5; n++) begin
      ea = {a[18:2], ord ? 2'(1 ^ k) : 2'(1 + k)};
      check("b_addr", mem_addr, 32'(ea));
      check("b_rd", mem_read, 1);
      step_n = (n == 2);
      @(negedge clock);
      check("b_q", data_out, 32'(18'(ea * 3 + 5)));
      check("b_oe", data_oe, 1);
      if (n != 2) k++; // a wait cycle holds the counter
    end
    step_n = 1'b1;
    deselect;
  endtask
  // write control table: global, gated lane and ungated cases
  task automatic t_write;
    logic [4:0] tgw, tgate;
    logic [9:0] tsel, tlw;
    logic [1:0] lw;
    tgw = 5'b10111;
    tgate = 5'b01100;
    tsel = {2'b00, 2'b11, 2'b00, 2'b01, 2'b10};
    tlw = {2'b11, 2'b11, 2'b00, 2'b10, 2'b01};
    for (int i = 0; i < 5; i++) begin
      // bus turnaround: a read's drive must end before host data
      @(negedge clock);
      lw = tlw[2*i+:2];
      addr = 19'h00100 + 19'(i);
      host_d = 18'h2d0c3 ^ 18'(i << 4);
      cs_n = 1'b0;
      sec = 1'b1;
      ctrl_n = 1'b0;
      gw_n = tgw[i];
      gate_n = tgate[i];
      sel_n = tsel[2*i+:2]; // host pulls a lane low to write
      @(negedge clock);
      gw_n = 1'b1;
      gate_n = 1'b1;
      sel_n = 2'b11;
      check("w_lanes", mem_lane_write, 32'(lw));
      check("w_rd", mem_read, 32'(lw == 2'b00));
      check("w_addr", mem_addr, 32'(addr));
      if (lw != 2'b00) check("w_data", mem_wdata, 32'(host_d));
      deselect;
      check("w_oe", data_oe, 32'(lw == 2'b00));
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    addr = '0;
    proc_n = 1'b1;
    ctrl_n = 1'b1;
    step_n = 1'b1;
    order = 1'b0;
    cs_n = 1'b1;
    sec = 1'b0;
    gw_n = 1'b1;
    gate_n = 1'b1;
    sel_n = 2'b11;
    host_d = '0;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    check("rst_sel", port_selected, 0);
    check("rst_oe", data_oe, 0);
    t_gate;
    t_float;
    t_burst(1'b0);
    t_burst(1'b1);
    t_write;
    conclude;
  end
  // watchdog: the run needs well under a hundred cycles
  initial begin
    #(4000 * 25);
    num_errors++;
    conclude;
  end
endmodule
`default_nettype wire

//--- rtl/sbsc_burst.sv
// two-bit burst address generator, linear or interleaved order
`default_nettype none
module sbsc_burst import sbsc_pkg::*; #(
  parameter int BW = SBSC_BURST_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control
  input wire logic load,
  input wire logic step,
  input wire logic interleave,
  input wire logic [BW-1:0] start,
  // next low address bits
  output logic [BW-1:0] low_nxt
);
  logic [BW-1:0] start_r;
  logic [BW-1:0] cnt_r;
  logic [BW-1:0] start_nxt;
  logic [BW-1:0] cnt_nxt;

  // a load restarts the count, a step advances it
  always_comb begin
    start_nxt = load ? start : start_r;
    if (load) begin
      cnt_nxt = SBSC_CNT_RST;
    end else if (step) begin
      cnt_nxt = cnt_r + 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
    // sum is cut to BW bits so it wraps inside the block
    if (interleave) begin
      low_nxt = start_nxt ^ cnt_nxt;
    end else begin
      low_nxt = start_nxt + cnt_nxt;
    end
  end

  // count state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_r <= SBSC_CNT_RST;
      cnt_r <= SBSC_CNT_RST;
    end else begin
      start_r <= start_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

//--- rtl/sbsc_pkg.sv
// shared constants of the synchronous burst sram control port
`default_nettype none
package sbsc_pkg;
  // ==========================================================
  // organisation
  localparam int SBSC_LANE_W = 9;      // bits per byte lane
  localparam int SBSC_LANES = 2;       // lanes of the 18-bit part
  localparam int SBSC_LANES_WIDE = 4;  // lanes of the 36-bit part
  localparam int SBSC_ADDR_W = 19;     // word address of 18-bit part
  localparam int SBSC_BURST_W = 2;     // internal burst counter bits
  // ==========================================================
  // reset values
  localparam logic [SBSC_BURST_W-1:0] SBSC_CNT_RST = 2'h0;
  localparam logic SBSC_OE_RST = 1'b0;
  // ==========================================================
  // port state, one-hot
  typedef enum logic [1:0] {
    SBSC_IDLE  = 2'b01,
    SBSC_BURST = 2'b10
  } sbsc_state_t;
endpackage
`default_nettype wire

//--- rtl/sbsc_port.sv
// synchronous control port of a pipelined burst sram
`default_nettype none
// ==========================================================
module sbsc_port import sbsc_pkg::*; #(
  parameter int LANES = SBSC_LANES,
  parameter int LANE_W = SBSC_LANE_W,
  parameter int ADDR_W = SBSC_ADDR_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // address and strobes
  input wire logic [ADDR_W-1:0] addr,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic burst_order_high,
  // chip selects
  input wire logic chip_select_n,
  input wire logic secondary_select_high,
  // write controls, lane 0 is the first lane
  input wire logic full_word_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [LANES-1:0] lane_write_sel_n,
  // data pin, split three ways
  input wire logic [LANES*LANE_W-1:0] data_in,
  output logic [LANES*LANE_W-1:0] data_out,
  output logic data_oe,
  // memory core side
  input wire logic [LANES*LANE_W-1:0] core_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [LANES-1:0] mem_lane_write,
  output logic [LANES*LANE_W-1:0] mem_wdata,
  output logic mem_read,
  output logic port_selected
);
  localparam int DW = LANES * LANE_W;
  localparam int BW = SBSC_BURST_W;

  // ==========================================================
  // state and outputs
  sbsc_state_t state_r;
  sbsc_state_t state_nxt;
  logic [ADDR_W-1:0] mem_addr_r;
  logic [LANES-1:0] mem_lane_write_r;
  logic [DW-1:0] mem_wdata_r;
  logic mem_read_r;
  logic [DW-1:0] data_out_r;
  logic data_oe_r;

  // ==========================================================
  // decoded controls of this edge
  logic select_ok;
  logic proc_go;
  logic ctrl_go;
  logic load;
  logic cont;
  logic step;
  logic access;
  logic is_write;
  logic [LANES-1:0] lane_write;
  logic data_hiz;
  logic [BW-1:0] low_nxt;
  logic [ADDR_W-1:0] addr_nxt;

  // ==========================================================
  // select and strobe qualification
  // every decision below looks at the pins of one edge only
  assign select_ok = !chip_select_n && secondary_select_high;
  // processor strobe is dead while the primary select is high
  assign proc_go = !proc_addr_strobe_n && !chip_select_n;
  assign ctrl_go = !ctrl_addr_strobe_n && !proc_go;
  assign load = proc_go || ctrl_go;
  // a burst or wait cycle follows an access without a new strobe
  assign cont = (state_r == SBSC_BURST) && !load;
  assign step = cont && !burst_step_n;
  assign access = (load && select_ok) || cont;
  // processor-started cycles are always reads
  assign is_write = !proc_go && (|lane_write);

  // ==========================================================
  // write decode and burst counter
  sbsc_wdec #(
    .LANES(LANES)
  ) u_wdec (
    .full_word_write_n(full_word_write_n),
    .byte_write_gate_n(byte_write_gate_n),
    .lane_write_sel_n(lane_write_sel_n),
    .lane_write(lane_write),
    .data_hiz(data_hiz)
  );

  sbsc_burst #(
    .BW(BW)
  ) u_burst (
    .clock(clock),
    .reset_n(reset_n),
    .load(load),
    .step(step),
    .interleave(burst_order_high),
    .start(addr[BW-1:0]),
    .low_nxt(low_nxt)
  );

  // upper bits come from the pins on a load, else stay put
  always_comb begin
    if (load) begin
      addr_nxt = {addr[ADDR_W-1:BW], low_nxt};
    end else begin
      addr_nxt = {mem_addr_r[ADDR_W-1:BW], low_nxt};
    end
  end

  // ==========================================================
  // port state: a strobe selects or deselects the port
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SBSC_IDLE: begin
        if (load && select_ok) begin
          state_nxt = SBSC_BURST;
        end
      end
      SBSC_BURST: begin
        if (load && !select_ok) begin
          state_nxt = SBSC_IDLE;
        end
      end
      default: begin
        state_nxt = SBSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SBSC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // address register, updated only when an access happens
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr_r <= '0;
    end else if (access) begin
      mem_addr_r <= addr_nxt;
    end
  end

  // per-lane write strobes, one cycle per access
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_lane_write_r <= '0;
    end else if (access && is_write) begin
      mem_lane_write_r <= lane_write;
    end else begin
      mem_lane_write_r <= '0;
    end
  end

  // write data taken on the same edge as the write controls
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_wdata_r <= '0;
    end else if (access && is_write) begin
      mem_wdata_r <= data_in;
    end
  end

  // read strobe to the core
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_read_r <= 1'b0;
    end else begin
      mem_read_r <= access && !is_write;
    end
  end

  // ==========================================================
  // read data pipeline: core answers while mem_read is high,
  // the pins show it one cycle later
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      data_out_r <= '0;
    end else if (mem_read_r) begin
      data_out_r <= core_rdata;
    end
  end

  // a write on the pins always wins over a pending read, but the drive
  // only ends at the write edge, so the host must wait out any read drive
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      data_oe_r <= SBSC_OE_RST;
    end else begin
      data_oe_r <= mem_read_r && !data_hiz;
    end
  end

  // ==========================================================
  // outputs
  assign data_out = data_out_r;
  assign data_oe = data_oe_r;
  assign mem_addr = mem_addr_r;
  assign mem_lane_write = mem_lane_write_r;
  assign mem_wdata = mem_wdata_r;
  assign mem_read = mem_read_r;
  assign port_selected = state_r[1];

  // ==========================================================
  // checks
  a_hiz_on_write: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!byte_write_gate_n && !(&lane_write_sel_n)) |=> !data_oe)
    else $error("data pins driven during gated byte write");

  a_gate_blocks: assert property (
    @(posedge clock) disable iff (!reset_n)
    (byte_write_gate_n && full_word_write_n) |=> (mem_lane_write == '0))
    else $error("lane write without gate or global write");

  a_full_word: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!full_word_write_n && !proc_go && access) |=> (&mem_lane_write))
    else $error("global write did not hit every lane");

  a_lane_map: assert property (
    @(posedge clock) disable iff (!reset_n)
    (full_word_write_n && !byte_write_gate_n && access && !proc_go)
    |=> (mem_lane_write == ~$past(lane_write_sel_n)))
    else $error("lane write does not follow its select");

  a_wdata_take: assert property (
    @(posedge clock) disable iff (!reset_n)
    (|mem_lane_write) |-> (mem_wdata == $past(data_in)))
    else $error("write data not from the write edge");

  a_proc_gated: assert property (
    @(posedge clock) disable iff (!reset_n)
    (chip_select_n && ctrl_addr_strobe_n && state_r == SBSC_IDLE)
    |=> (state_r == SBSC_IDLE) && !mem_read && (mem_lane_write == '0))
    else $error("processor strobe acted while deselected");

  // a gated processor strobe must not end a running burst either
  a_proc_ignored: assert property (
    @(posedge clock) disable iff (!reset_n)
    (chip_select_n && ctrl_addr_strobe_n && port_selected) |=> port_selected)
    else $error("gated processor strobe ended the burst");

  a_proc_read: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!proc_addr_strobe_n && !chip_select_n && secondary_select_high)
    |=> mem_read && (mem_addr == $past(addr)) && port_selected)
    else $error("processor strobe did not start a read");

  a_ctrl_load: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!ctrl_addr_strobe_n && proc_addr_strobe_n && select_ok)
    |=> port_selected && (mem_addr == $past(addr)))
    else $error("controller strobe did not load the address");

  a_ctrl_desel: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!ctrl_addr_strobe_n && !secondary_select_high) |=> !port_selected)
    else $error("controller strobe did not deselect");

  a_wait_hold: assert property (
    @(posedge clock) disable iff (!reset_n)
    (cont && burst_step_n) |=> (mem_addr == $past(mem_addr)))
    else $error("wait cycle moved the address");

  a_burst_block: assert property (
    @(posedge clock) disable iff (!reset_n)
    cont |=> (mem_addr[ADDR_W-1:BW] == $past(mem_addr[ADDR_W-1:BW])))
    else $error("burst carried into upper address bits");

  a_linear_step: assert property (
    @(posedge clock) disable iff (!reset_n)
    (step && !burst_order_high && $past(cont && !burst_step_n
      && !burst_order_high))
    |=> (mem_addr[BW-1:0] == $past(mem_addr[BW-1:0]) + 2'h1))
    else $error("linear burst order broken");

  a_oe_after_rd: assert property (
    @(posedge clock) disable iff (!reset_n)
    data_oe |-> $past(mem_read))
    else $error("data pins driven without a read");
endmodule
`default_nettype wire

//--- rtl/sbsc_wdec.sv
// write select decode: global write, byte gate and lane selects
`default_nettype none
module sbsc_wdec import sbsc_pkg::*; #(
  parameter int LANES = SBSC_LANES
) (
  // write controls, all active low
  input wire logic full_word_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [LANES-1:0] lane_write_sel_n,
  // decoded
  output logic [LANES-1:0] lane_write,
  output logic data_hiz
);
  // global write wins over the gate and the lane selects
  function automatic logic [LANES-1:0] lanes_of(
    input logic gw_n, input logic gate_n, input logic [LANES-1:0] sel_n);
    if (!gw_n) begin
      lanes_of = '1;
    end else if (!gate_n) begin
      lanes_of = ~sel_n;
    end else begin
      lanes_of = '0;
    end
  endfunction

  // data pins float for any gated lane select or a global write
  assign lane_write = lanes_of(full_word_write_n, byte_write_gate_n,
                               lane_write_sel_n);
  assign data_hiz = (!byte_write_gate_n && !(&lane_write_sel_n))
                    || !full_word_write_n;
endmodule
`default_nettype wire
